// ### hw/asr_pkg.sv
// Package holding the constants shared by both ends of the serial receive link.
package asr_pkg;
    // Register offsets of the receiver's software port.
    localparam logic [2:0] ASR_STATUS_ADDR = 3'h0;
    localparam logic [2:0] ASR_DATA_ADDR = 3'h1;
    localparam logic [2:0] ASR_BAUD_ADDR = 3'h2;
    localparam logic [2:0] ASR_EXT_ADDR = 3'h3;
    localparam logic [2:0] ASR_CTRL1_ADDR = 3'h4;
    localparam logic [2:0] ASR_CTRL2_ADDR = 3'h5;
    // Status bit positions.
    localparam int ASR_SR_FULL = 5;
    localparam int ASR_SR_IDLE = 4;
    localparam int ASR_SR_OVR = 3;
    localparam int ASR_SR_NOISE = 2;
    localparam int ASR_SR_FRAME = 1;
    // Control bit positions.
    localparam int ASR_C1_NINTH = 7;
    localparam int ASR_C1_WL = 4;
    localparam int ASR_C2_RXIE = 5;
    localparam int ASR_C2_IDLEIE = 4;
    localparam int ASR_C2_ON = 2;
    // Baud field positions.
    localparam int ASR_PRE_HI = 7;
    localparam int ASR_PRE_LO = 6;
    localparam int ASR_RDIV_HI = 2;
    // Oversampling: sixteen samples per bit, majority window 8..10.
    localparam logic [3:0] ASR_OVS_LAST = 4'hF;
    localparam logic [3:0] ASR_SMP_A = 4'h8;
    localparam logic [3:0] ASR_SMP_B = 4'h9;
    localparam logic [3:0] ASR_SMP_C = 4'hA;
    // Prescaler factors minus one for codes 0..3.
    localparam logic [3:0] ASR_PRE0 = 4'h0;
    localparam logic [3:0] ASR_PRE1 = 4'h2;
    localparam logic [3:0] ASR_PRE2 = 4'h3;
    localparam logic [3:0] ASR_PRE3 = 4'hC;
    localparam logic [7:0] ASR_ZERO8 = 8'h00;
    // Receiver states, Gray coded along the usual path.
    typedef enum logic [1:0] {
        ASR_IDLE = 2'b00,
        ASR_START = 2'b01,
        ASR_DATA = 2'b11,
        ASR_STOP = 2'b10
    } asr_state_e;
endpackage : asr_pkg

// ### hw/asr_link_if.sv
// Interface carrying the single serial line between transmitter and receiver.
`timescale 1ns/100ps
interface asr_link_if;
    // Serial line, idle high.
    logic serial_in_pin;
    // Transmitter end drives the line.
    modport far_end (output serial_in_pin);
    // Receiver end reads the line.
    modport rx_end (input serial_in_pin);
endinterface : asr_link_if

// ### hw/asr_rate_div.sv
// Divider making the sixteen-times sample enable from the bus clock.
`timescale 1ns/100ps
module asr_rate_div
    import asr_pkg::*;
(
    // Clock and reset.
    input wire logic clock,
    input wire logic rstn,
    // Divider settings.
    input wire logic [1:0] pre_sel,
    input wire logic [2:0] rate_sel,
    // Sample enable pulse.
    output logic tick
);
    logic [3:0] pre_cnt; // First prescaler counter.
    logic [6:0] rate_cnt; // Power-of-two counter.
    logic [3:0] next_pre_cnt;
    logic [6:0] next_rate_cnt;
    logic next_tick;
    logic [3:0] pre_top; // Decoded prescaler terminal.
    logic [6:0] rate_top; // Decoded rate terminal.

    ////////////////////////////////////////////////////////////////////////
    // Two cascaded counters; the tick fires when both wrap.
    always_comb begin
        case (pre_sel)
            2'd0: pre_top = ASR_PRE0;
            2'd1: pre_top = ASR_PRE1;
            2'd2: pre_top = ASR_PRE2;
            default: pre_top = ASR_PRE3;
        endcase
        rate_top = 7'((8'h01 << rate_sel) - 8'h01);
        next_pre_cnt = pre_cnt + 4'h1;
        next_rate_cnt = rate_cnt;
        next_tick = 1'b0;
        if (pre_cnt >= pre_top) begin
            next_pre_cnt = 4'h0;
            next_rate_cnt = rate_cnt + 7'h01;
            if (rate_cnt >= rate_top) begin
                next_rate_cnt = 7'h00;
                next_tick = 1'b1;
            end
        end
    end

    // Registers of the divider.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            pre_cnt <= 4'h0;
            rate_cnt <= 7'h00;
            tick <= 1'b0;
        end else begin
            pre_cnt <= next_pre_cnt;
            rate_cnt <= next_rate_cnt;
            tick <= next_tick;
        end
    end
endmodule : asr_rate_div

// ### hw/asr_receiver.sv
// Receiver end: oversampling serial receiver with software register port.
// Functional notes
// - Eight or nine data bits; ninth kept.
// - Bits arrive and shift in LSB first.
// - Setting rx_on starts start-bit hunting.
// - Completed character loads buffer, sets full.
// - Receive irq needs enable and core unmasked.
// - Full clears on status access then data read.
// - Software clears full before next character.
// - Software sets length and rate before enabling.
// - Break character counts as framing error.
// - Idle frame acts as character, own irq.
// - Overrun when full still set; no transfer.
// - Overrun sets flag, keeps buffer, irq.
// - Overrun flag cleared by status-data sequence.
// - Samples 8,9,10 must agree, else noise.
// - Start noise needs edge and three samples.
// - Noise rises with full, data transferred.
// - Noise cleared by status then data read.
// - False start discarded; noise kept hidden.
// - Sample clock: prescaler times power-of-two divisor.
// - Data read returns buffer; writes go elsewhere.
`timescale 1ns/100ps
module asr_receiver
    import asr_pkg::*;
(
    // Clock and reset.
    input wire logic clock,
    input wire logic rstn,
    // Serial link.
    asr_link_if.rx_end link,
    // Software register port.
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // CPU interrupt mask input and request output.
    input wire logic core_mask_flag,
    output logic irq,
    // Transmit holding register, filled by data port writes.
    output logic [7:0] tx_hold
);
    ////////////////////////////////////////////////////////////////////////
    // Declarations.
    logic sync1, sync2, line_q; // Pin synchroniser and previous sample.
    logic tick; // Sixteen-times sample enable.
    asr_state_e state, next_state; // Receiver state.
    logic [3:0] ovs, next_ovs; // Sample index within a bit.
    logic [3:0] bitn, next_bitn; // Data bit index.
    logic [2:0] smp, next_smp; // Samples 8, 9 and 10.
    logic [8:0] shreg, next_shreg; // Input shift register.
    logic fnoise, next_fnoise; // Noise seen in the current or hidden frame.
    logic [7:0] idle_cnt, next_idle_cnt; // Ticks of high line while hunting.
    logic idle_armed, next_idle_armed; // A frame ended since the last idle frame.
    logic [7:0] rx_buffer, next_rx_buffer; // Buffer read at the data port.
    logic ninth_data_bit, next_ninth;
    logic rx_full_flag, idle_flag, overrun_flag, noise_flag, frame_error_flag;
    logic next_full, next_idle, next_ovr, next_noise, next_ferr;
    logic armed, next_armed; // Status register was accessed.
    logic [7:0] baud_select_register, extended_rx_rate_register, ctrl1, ctrl2;
    logic [7:0] next_baud, next_ext, next_ctrl1, next_ctrl2;
    logic [7:0] next_rdata, next_tx_hold;
    logic next_irq;
    logic done, done_idle, done_ferr, done_noise; // Frame end events.
    logic rx_on, word_length_select, rx_irq_enable, idle_irq_enable;
    logic maj; // Majority of the three samples.

    // Returns true when the three mid-bit samples disagree.
    function automatic logic asr_disagree(input logic [2:0] s);
        asr_disagree = (s != 3'b000) && (s != 3'b111);
    endfunction : asr_disagree

    assign rx_on = ctrl2[ASR_C2_ON];
    assign word_length_select = ctrl1[ASR_C1_WL];
    assign rx_irq_enable = ctrl2[ASR_C2_RXIE];
    assign idle_irq_enable = ctrl2[ASR_C2_IDLEIE];
    assign maj = (smp[0] & smp[1]) | (smp[0] & smp[2]) | (smp[1] & smp[2]);

    ////////////////////////////////////////////////////////////////////////
    // Sample clock divider.
    asr_rate_div u_div (
        .clock(clock),
        .rstn(rstn),
        .pre_sel(baud_select_register[ASR_PRE_HI:ASR_PRE_LO]),
        .rate_sel(baud_select_register[ASR_RDIV_HI:0]),
        .tick(tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // Frame engine: hunt, start check, data bits, stop bit.
    always_comb begin
        next_state = state;
        next_ovs = ovs;
        next_bitn = bitn;
        next_smp = smp;
        next_shreg = shreg;
        next_fnoise = fnoise;
        done = 1'b0;
        done_idle = 1'b0;
        done_ferr = 1'b0;
        done_noise = fnoise;
        if (!rx_on) begin
            next_state = ASR_IDLE;
        end else if (tick) begin
            next_ovs = ovs + 4'h1;
            if (ovs == ASR_SMP_A) next_smp[0] = line_q;
            if (ovs == ASR_SMP_B) next_smp[1] = line_q;
            if (ovs == ASR_SMP_C) next_smp[2] = line_q;
            case (state)
                ASR_IDLE: begin
                    // Hunt for a falling edge; restart sample numbering there.
                    if (line_q && !sync2) begin
                        next_state = ASR_START;
                        next_ovs = 4'h1;
                    end
                end
                ASR_START: begin
                    if (ovs == ASR_OVS_LAST) begin
                        // Edge was valid; split samples mark the frame noisy.
                        if (asr_disagree(smp)) next_fnoise = 1'b1;
                        if (!maj) begin
                            next_state = ASR_DATA;
                            next_bitn = 4'h0;
                        end else begin
                            // False start: drop frame, noise stays hidden.
                            next_state = ASR_IDLE;
                        end
                    end
                end
                ASR_DATA: begin
                    if (ovs == ASR_OVS_LAST) begin
                        if (asr_disagree(smp)) next_fnoise = 1'b1;
                        // Shift right so the first bit ends lowest.
                        next_shreg = {maj, shreg[8:1]};
                        next_bitn = bitn + 4'h1;
                        if (bitn == (word_length_select ? 4'h8 : 4'h7)) begin
                            next_state = ASR_STOP;
                        end
                    end
                end
                ASR_STOP: begin
                    if (ovs == ASR_OVS_LAST) begin
                        next_state = ASR_IDLE;
                        done = 1'b1;
                        done_noise = fnoise | asr_disagree(smp);
                        done_ferr = ~maj;
                        next_fnoise = 1'b0;
                    end
                end
                default: next_state = ASR_IDLE;
            endcase
        end
        // Idle-frame detector: eleven or twelve bit times of high line once armed.
        next_idle_cnt = idle_cnt;
        next_idle_armed = idle_armed;
        if (!rx_on || state != ASR_IDLE || !line_q) begin
            next_idle_cnt = ASR_ZERO8;
        end else if (tick && idle_armed) begin
            next_idle_cnt = idle_cnt + 8'h01;
            if (idle_cnt == {word_length_select ? 4'hB : 4'hA, ASR_OVS_LAST}) begin
                done_idle = 1'b1;
                next_idle_armed = 1'b0;
                next_idle_cnt = ASR_ZERO8;
            end
        end
        if (done) next_idle_armed = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Flags, buffer and register port.
    always_comb begin
        next_full = rx_full_flag;
        next_idle = idle_flag;
        next_ovr = overrun_flag;
        next_noise = noise_flag;
        next_ferr = frame_error_flag;
        next_rx_buffer = rx_buffer;
        next_ninth = ninth_data_bit;
        next_armed = armed;
        next_baud = baud_select_register;
        next_ext = extended_rx_rate_register;
        next_ctrl1 = ctrl1;
        next_ctrl2 = ctrl2;
        next_tx_hold = tx_hold;
        next_rdata = ASR_ZERO8;
        // Status access arms the clear; a data read completes it.
        if (rd && addr == ASR_STATUS_ADDR) next_armed = 1'b1;
        if (rd && addr == ASR_DATA_ADDR && armed) begin
            next_full = 1'b0;
            next_ovr = 1'b0;
            next_noise = 1'b0;
            next_ferr = 1'b0;
            next_idle = 1'b0;
            next_armed = 1'b0;
        end
        // Events are applied after the clear so a same-cycle set wins.
        if (done || done_idle) begin
            if (rx_full_flag) begin
                next_ovr = 1'b1;
            end else begin
                next_full = 1'b1;
                next_noise = done_noise;
                next_ferr = done_ferr;
                next_idle = done_idle;
                if (done) begin
                    next_rx_buffer = word_length_select ? shreg[7:0] : next_shreg[8:1];
                    next_ninth = shreg[8];
                end
            end
        end
        if (wr) begin
            case (addr)
                ASR_DATA_ADDR: next_tx_hold = wdata;
                ASR_BAUD_ADDR: next_baud = wdata;
                ASR_EXT_ADDR: next_ext = wdata;
                ASR_CTRL1_ADDR: next_ctrl1 = wdata;
                ASR_CTRL2_ADDR: next_ctrl2 = wdata;
                default: ;
            endcase
        end
        if (rd) begin
            case (addr)
                ASR_STATUS_ADDR: next_rdata = {2'b00, rx_full_flag, idle_flag, overrun_flag,
                    noise_flag, frame_error_flag, 1'b0};
                ASR_DATA_ADDR: next_rdata = rx_buffer;
                ASR_BAUD_ADDR: next_rdata = baud_select_register;
                ASR_EXT_ADDR: next_rdata = extended_rx_rate_register;
                ASR_CTRL1_ADDR: next_rdata = {ninth_data_bit, ctrl1[6:0]};
                ASR_CTRL2_ADDR: next_rdata = ctrl2;
                default: next_rdata = ASR_ZERO8;
            endcase
        end
        // Noise alone raises no request; it rides on the full flag.
        next_irq = !core_mask_flag && ((rx_irq_enable && (next_full || next_ovr))
            || (idle_irq_enable && next_idle));
    end

    ////////////////////////////////////////////////////////////////////////
    // All registers of the receiver.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            sync1 <= 1'b1;
            sync2 <= 1'b1;
            line_q <= 1'b1;
            state <= ASR_IDLE;
            ovs <= 4'h0;
            bitn <= 4'h0;
            smp <= 3'b111;
            shreg <= 9'h000;
            fnoise <= 1'b0;
            idle_cnt <= ASR_ZERO8;
            idle_armed <= 1'b0;
            rx_buffer <= ASR_ZERO8;
            ninth_data_bit <= 1'b0;
            rx_full_flag <= 1'b0;
            idle_flag <= 1'b0;
            overrun_flag <= 1'b0;
            noise_flag <= 1'b0;
            frame_error_flag <= 1'b0;
            armed <= 1'b0;
            baud_select_register <= ASR_ZERO8;
            extended_rx_rate_register <= ASR_ZERO8;
            ctrl1 <= ASR_ZERO8;
            ctrl2 <= ASR_ZERO8;
            tx_hold <= ASR_ZERO8;
            rdata <= ASR_ZERO8;
            irq <= 1'b0;
        end else begin
            sync1 <= link.serial_in_pin;
            sync2 <= sync1;
            if (tick) line_q <= sync2;
            state <= next_state;
            ovs <= next_ovs;
            bitn <= next_bitn;
            smp <= next_smp;
            shreg <= next_shreg;
            fnoise <= next_fnoise;
            idle_cnt <= next_idle_cnt;
            idle_armed <= next_idle_armed;
            rx_buffer <= next_rx_buffer;
            ninth_data_bit <= next_ninth;
            rx_full_flag <= next_full;
            idle_flag <= next_idle;
            overrun_flag <= next_ovr;
            noise_flag <= next_noise;
            frame_error_flag <= next_ferr;
            armed <= next_armed;
            baud_select_register <= next_baud;
            extended_rx_rate_register <= next_ext;
            ctrl1 <= next_ctrl1;
            ctrl2 <= next_ctrl2;
            tx_hold <= next_tx_hold;
            rdata <= next_rdata;
            irq <= next_irq;
        end
    end
endmodule : asr_receiver

// ### hw/asr_transmitter.sv
// Far end: simple serial transmitter driving the receive line.
`timescale 1ns/100ps
module asr_transmitter
    import asr_pkg::*;
(
    // Clock and reset.
    input wire logic clock,
    input wire logic rstn,
    // Serial link.
    asr_link_if.far_end link,
    // Bit rate and format.
    input wire logic [1:0] pre_sel,
    input wire logic [2:0] rate_sel,
    input wire logic nine_bits,
    // Character request.
    input wire logic send,
    input wire logic [8:0] char_in,
    output logic busy
);
    logic tick; // Sixteen-times enable from the transmitter's own divider.
    logic [10:0] frame, next_frame; // Start, data LSB first, stop.
    logic [3:0] bits_left, next_bits_left;
    logic [3:0] sub, next_sub;
    logic next_busy;
    logic line, next_line;

    asr_rate_div u_div (
        .clock(clock),
        .rstn(rstn),
        .pre_sel(pre_sel),
        .rate_sel(rate_sel),
        .tick(tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // Shift out one bit every sixteen ticks, least significant first.
    always_comb begin
        next_frame = frame;
        next_bits_left = bits_left;
        next_sub = sub;
        next_busy = busy;
        next_line = line;
        if (!busy && send) begin
            next_frame = nine_bits ? {1'b1, char_in, 1'b0} : {1'b1, 1'b1, char_in[7:0], 1'b0};
            next_bits_left = nine_bits ? 4'hB : 4'hA;
            next_sub = 4'h0;
            next_busy = 1'b1;
        end else if (busy && tick) begin
            next_sub = sub + 4'h1;
            if (sub == 4'h0) begin
                next_line = frame[0];
                next_frame = {1'b1, frame[10:1]};
            end
            if (sub == ASR_OVS_LAST) begin
                next_bits_left = bits_left - 4'h1;
                if (bits_left == 4'h1) begin
                    next_busy = 1'b0;
                    next_line = 1'b1;
                end
            end
        end
    end

    // Registers of the transmitter.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            frame <= 11'h7FF;
            bits_left <= 4'h0;
            sub <= 4'h0;
            busy <= 1'b0;
            line <= 1'b1;
        end else begin
            frame <= next_frame;
            bits_left <= next_bits_left;
            sub <= next_sub;
            busy <= next_busy;
            line <= next_line;
        end
    end

    assign link.serial_in_pin = line;
endmodule : asr_transmitter

// ### sim/asr_link_monitor.sv
// Checker watching the serial line and the receiver's software port.
`timescale 1ns/100ps
module asr_link_monitor
    import asr_pkg::*;
(
    // Clock and reset.
    input wire logic clock,
    input wire logic rstn,
    // Serial line and transmitter state.
    input wire logic serial_in_pin,
    input wire logic busy,
    // Receiver software port and interrupt.
    input wire logic [2:0] addr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic core_mask_flag,
    input wire logic irq
);
    // Longest wait from a send to the start bit, in clocks.
    localparam int LINE_WAIT = 1000;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////////////////////////
    // A masked core must never see a request on the next cycle.
    a_irq_when_masked: assert property (core_mask_flag |=> !irq)
        else $error("irq raised while masked");
    // A rising request needs the core unmasked one cycle earlier.
    a_irq_rise_unmasked: assert property ($rose(irq) |-> $past(!core_mask_flag))
        else $error("irq rose after a masked cycle");
    // Read data stands only in the cycle after a read.
    a_rdata_quiet: assert property (!rd |=> rdata == ASR_ZERO8)
        else $error("rdata not zero without a read");
    // Unused status bits always read as zero.
    a_status_spare: assert property (rd && addr == ASR_STATUS_ADDR |=>
        rdata[7:6] == 2'b00 && !rdata[0])
        else $error("status spare bits set");
    // Unmapped addresses read as zero.
    a_unmapped_zero: assert property (rd && addr > ASR_CTRL2_ADDR |=> rdata == ASR_ZERO8)
        else $error("unmapped read not zero");
    // The line idles high whenever no character is on its way.
    a_idle_line_high: assert property (!busy |-> serial_in_pin)
        else $error("line low while transmitter idle");
    // A start bit follows every accepted send within a bounded time.
    a_start_follows: assert property ($rose(busy) |-> ##[0:LINE_WAIT] !serial_in_pin)
        else $error("no start bit after send");
    // Every low bit lasts at least eight clocks.
    a_low_bit_long: assert property ($fell(serial_in_pin) |-> !serial_in_pin[*8])
        else $error("low bit too short");
    // A frame keeps the transmitter busy for many cycles.
    a_busy_frame: assert property ($rose(busy) |-> busy[*8])
        else $error("busy too short");
    // Main scenarios that must be reached.
    cover property ($rose(irq));
    cover property ($fell(busy));
    cover property (rd && addr == ASR_DATA_ADDR ##1 rdata != ASR_ZERO8);
endmodule : asr_link_monitor

// ### sim/tb_async_serial_receiver.sv
// Testbench sending characters into two receivers and checking the software view.
`timescale 1ns/100ps
module tb_async_serial_receiver;
    import asr_pkg::*;
    // Clock, reset and register port.
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic core_mask_flag = 1'b0;
    logic [7:0] rdata_a;
    logic [7:0] rdata_b;
    logic [7:0] tx_hold;
    logic irq_a;
    // Transmitter controls.
    logic [1:0] pre_sel = 2'h0;
    logic [2:0] rate_sel = 3'h0;
    logic nine_bits = 1'b0;
    logic send = 1'b0;
    logic [8:0] char_in = 9'h000;
    logic busy;
    // Last read values and counters.
    logic [7:0] seen_a;
    logic [7:0] seen_b;
    int errors = 0;
    int n_checks = 0;
    asr_link_if link ();
    asr_link_if link_b ();
    ////////////////////////////////////////////////////////////////////////////////
    asr_transmitter u_asr_transmitter (.clock(clock), .rstn(rstn), .link(link),
        .pre_sel(pre_sel), .rate_sel(rate_sel), .nine_bits(nine_bits), .send(send),
        .char_in(char_in), .busy(busy));
    asr_receiver u_asr_receiver (.clock(clock), .rstn(rstn), .link(link), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata_a), .core_mask_flag(core_mask_flag),
        .irq(irq_a), .tx_hold(tx_hold));
    // Second receiver on a line that the bench drives with faulty frames.
    asr_receiver u_asr_receiver_b (.clock(clock), .rstn(rstn), .link(link_b), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata_b), .core_mask_flag(core_mask_flag),
        .irq(), .tx_hold());
    asr_link_monitor u_asr_link_monitor (.clock(clock), .rstn(rstn),
        .serial_in_pin(link.serial_in_pin), .busy(busy), .addr(addr), .rd(rd),
        .rdata(rdata_a), .core_mask_flag(core_mask_flag), .irq(irq_a));
    // Free running 125 MHz clock.
    initial begin
        forever #4 clock = ~clock;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Compares one value and counts the outcome.
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    // Prints the verdict and ends the run.
    task automatic final_report();
        if (errors == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report
    // One-cycle register write.
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask : wr_reg
    // One-cycle register read; data is taken in the following cycle.
    task automatic rd_reg(input logic [2:0] a);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        seen_a = rdata_a;
        seen_b = rdata_b;
    endtask : rd_reg
    // Waits, then runs the status and data sequence that clears the flags.
    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        rd_reg(ASR_STATUS_ADDR);
        rd_reg(ASR_DATA_ADDR);
    endtask : settle
    // Sends one character and waits, bounded, until it has left the line.
    task automatic tx_char(input logic [8:0] c);
        int k;
        @(posedge clock);
        char_in <= c;
        send <= 1'b1;
        @(posedge clock);
        send <= 1'b0;
        k = 0;
        repeat (2) @(posedge clock);
        while (busy !== 1'b0 && k < 4000) begin
            @(posedge clock);
            k++;
        end
        if (k == 4000) begin
            errors++;
            final_report();
        end
        repeat (60) @(posedge clock);
    endtask : tx_char
    // Drives ten bits of sixteen clocks on the second line, bit g glitched mid-bit when g is below ten.
    task automatic raw_frame(input logic [9:0] bits, input int g);
        for (int i = 0; i < 10; i++) begin
            for (int j = 0; j < 16; j++) begin
                @(posedge clock);
                link_b.serial_in_pin <= bits[i] ^ (i == g && (j == 9 || j == 10));
            end
        end
        @(posedge clock);
        link_b.serial_in_pin <= 1'b1;
        repeat (60) @(posedge clock);
    endtask : raw_frame
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        link_b.serial_in_pin = 1'b1;
        repeat (16) @(posedge clock);
        rstn <= 1'b1;
        wr_reg(ASR_BAUD_ADDR, 8'h00);
        tx_char(9'h01E);
        rd_reg(ASR_STATUS_ADDR);
        chk("status off", seen_a, 8'h00);
        wr_reg(ASR_CTRL2_ADDR, 8'h24);
        tx_char(9'h01E);
        chk("irq set", {7'h00, irq_a}, 8'h01);
        rd_reg(ASR_STATUS_ADDR);
        chk("status full", seen_a, 8'h20);
        rd_reg(ASR_DATA_ADDR);
        chk("data", seen_a, 8'h1E);
        rd_reg(ASR_STATUS_ADDR);
        chk("status cleared", seen_a, 8'h00);
        rd_reg(3'h6);
        chk("unmapped", seen_a, 8'h00);
        repeat (250) @(posedge clock);
        rd_reg(ASR_STATUS_ADDR);
        chk("status idle", seen_a, 8'h30);
        rd_reg(ASR_DATA_ADDR);
        core_mask_flag <= 1'b1;
        tx_char(9'h0C3);
        chk("irq masked", {7'h00, irq_a}, 8'h00);
        core_mask_flag <= 1'b0;
        repeat (2) @(posedge clock);
        chk("irq unmasked", {7'h00, irq_a}, 8'h01);
        wr_reg(ASR_DATA_ADDR, 8'h6B);
        settle(0);
        chk("data after write", seen_a, 8'hC3);
        chk("tx hold", tx_hold, 8'h6B);
        settle(250);
        tx_char(9'h055);
        tx_char(9'h00F);
        rd_reg(ASR_STATUS_ADDR);
        chk("status overrun", seen_a, 8'h28);
        rd_reg(ASR_DATA_ADDR);
        chk("data kept", seen_a, 8'h55);
        rd_reg(ASR_STATUS_ADDR);
        chk("overrun cleared", seen_a, 8'h00);
        settle(250);
        wr_reg(ASR_CTRL1_ADDR, 8'h10);
        nine_bits <= 1'b1;
        tx_char(9'h133);
        rd_reg(ASR_CTRL1_ADDR);
        chk("ninth one", seen_a, 8'h90);
        settle(0);
        chk("data nine", seen_a, 8'h33);
        settle(250);
        tx_char(9'h0CC);
        rd_reg(ASR_CTRL1_ADDR);
        chk("ninth zero", seen_a, 8'h10);
        settle(250);
        nine_bits <= 1'b0;
        wr_reg(ASR_CTRL1_ADDR, 8'h00);
        wr_reg(ASR_BAUD_ADDR, 8'h49);
        pre_sel <= 2'h1;
        rate_sel <= 3'h1;
        tx_char(9'h096);
        settle(0);
        chk("data slow rate", seen_a, 8'h96);
        settle(1300);
        wr_reg(ASR_BAUD_ADDR, 8'h00);
        pre_sel <= 2'h0;
        rate_sel <= 3'h0;
        raw_frame(10'h000, 99);
        rd_reg(ASR_STATUS_ADDR);
        chk("status break", seen_b, 8'h22);
        rd_reg(ASR_DATA_ADDR);
        chk("data break", seen_b, 8'h00);
        settle(250);
        raw_frame(10'h2B4, 5);
        rd_reg(ASR_STATUS_ADDR);
        chk("status noise", seen_b, 8'h24);
        rd_reg(ASR_DATA_ADDR);
        chk("data noise", seen_b, 8'h5A);
        raw_frame(10'h2B4, 0);
        rd_reg(ASR_STATUS_ADDR);
        chk("start noise", seen_b, 8'h24);
        final_report();
    end
endmodule : tb_async_serial_receiver
